// file: src/cid_consts.svh
`ifndef CID_CONSTS_SVH
`define CID_CONSTS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define CID_CLK_NS 25
`define CID_T_POWERON_NS 15000000
`define CID_T_POWERON_LV_NS 40000000
`define CID_T_LONG_NS 1520000
`define CID_T_SHORT_NS 37000
`define CID_CYC_POWERON (`CID_T_POWERON_NS / `CID_CLK_NS)
`define CID_CYC_LONG (`CID_T_LONG_NS / `CID_CLK_NS)
`define CID_CYC_SHORT (`CID_T_SHORT_NS / `CID_CLK_NS)

// ****************************************************************
// Command bit positions and reset values
// ****************************************************************
`define CID_OP_ADDR_BIT 7
`define CID_OP_PATTERN_BIT 6
`define CID_OP_FUNC_BIT 5
`define CID_OP_SHIFT_BIT 4
`define CID_OP_DISPCTL_BIT 3
`define CID_OP_ENTRY_BIT 2
`define CID_OP_HOME_BIT 1
`define CID_OP_CLEAR_BIT 0
`define CID_STATUS_BUSY_BIT 7
`define CID_CFG_RESET 16'h0210
`endif

// file: src/cid_pkg.sv
package cid_pkg;
	typedef enum logic [1:0] {
		CID_TGT_DISPLAY = 2'h0,
		CID_TGT_PATTERN = 2'h1,
		CID_TGT_SEGMENT = 2'h2
	} cid_target_t;
	typedef enum logic [1:0] {
		CID_ST_INIT = 2'h0,
		CID_ST_IDLE = 2'h1,
		CID_ST_BUSY = 2'h2
	} cid_state_t;
	typedef struct packed {
		logic display_on;
		logic cursor_on;
		logic cursor_blink;
		logic wide_font_bit;
		logic invert_cursor;
		logic four_line_bit;
		logic bus_width_bit;
		logic two_line;
		logic extension_enable;
		logic pattern_blink_enable;
		logic low_power_bit;
		logic addr_increment;
		logic entry_shift;
		logic [2:0] dot_scroll_amount;
	} cid_cfg_t;
	typedef struct packed {
		cid_target_t target;
		logic [6:0] addr;
		logic [7:0] data;
	} cid_ram_wr_t;
endpackage

// file: src/cid_top.sv
`timescale 1ns/100ps
`include "cid_consts.svh"
module cid_top #(
	parameter int POWERON_CYCLES = `CID_CYC_POWERON,
	parameter int LONG_CYCLES = `CID_CYC_LONG
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Host transfer strobes, one cycle each
	input wire logic host_wr_stb,
	input wire logic host_rd_stb,
	input wire logic register_select_line,
	input wire logic [7:0] host_data_in,
	output logic [7:0] host_data_out,
	// Pins and RAM read path
	input wire logic extension_pin,
	input wire logic [7:0] ram_rd_data,
	// RAM access
	output logic ram_wr_stb,
	output cid_pkg::cid_ram_wr_t ram_wr,
	output cid_pkg::cid_target_t ram_target,
	output logic [6:0] ram_pointer,
	output logic display_clear_stb,
	// Settings
	output cid_pkg::cid_cfg_t cfg,
	output logic [6:0] display_offset,
	output logic low_power_active
);
	localparam int SHORT_CYCLES = `CID_CYC_SHORT;

	// ****************************************************************
	// Reset release
	// ****************************************************************
	logic rst_meta_reg;
	logic rst_n_sync;

	// Release through two flops; assertion stays asynchronous
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_reg <= 1'b0;
			rst_n_sync <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n_sync <= rst_meta_reg;
		end
	end

	// ****************************************************************
	// Decoder state
	// ****************************************************************
	cid_pkg::cid_state_t state_reg, state_next;
	cid_pkg::cid_cfg_t cfg_reg, cfg_next;
	cid_pkg::cid_ram_wr_t ram_wr_reg, ram_wr_next;
	cid_pkg::cid_target_t target_reg, target_next;
	logic [19:0] cnt_reg, cnt_next;
	logic [6:0] ptr_reg, ptr_next;
	logic [6:0] offset_reg, offset_next;
	logic [7:0] dout_reg, dout_next;
	logic [3:0] hi_nib_reg, hi_nib_next;
	logic nib_phase_reg, nib_phase_next;
	logic pat_sel_reg, pat_sel_next;
	logic wr_stb_reg, wr_stb_next;
	logic clr_stb_reg, clr_stb_next;
	logic lowpwr_act_reg, lowpwr_act_next;
	logic [7:0] cmd;
	logic [7:0] rbyte;
	logic idle;
	logic xfer_done;

	// Pointer step, wrapped to the width of the target RAM
	function automatic logic [6:0] cid_step(input logic [6:0] p,
		input logic up, input cid_pkg::cid_target_t t);
		logic [6:0] n;
		n = up ? 7'(p + 7'h01) : 7'(p - 7'h01);
		if (t == cid_pkg::CID_TGT_PATTERN)
			n = {1'b0, n[5:0]};
		else if (t == cid_pkg::CID_TGT_SEGMENT)
			n = {4'h0, n[2:0]};
		return n;
	endfunction

	// Command decode, busy timing and host transfers
	always_comb begin
		state_next = state_reg;
		cfg_next = cfg_reg;
		ram_wr_next = ram_wr_reg;
		cnt_next = cnt_reg;
		ptr_next = ptr_reg;
		offset_next = offset_reg;
		dout_next = dout_reg;
		hi_nib_next = hi_nib_reg;
		nib_phase_next = nib_phase_reg;
		pat_sel_next = pat_sel_reg;
		wr_stb_next = 1'b0;
		clr_stb_next = 1'b0;
		lowpwr_act_next = cfg_reg.low_power_bit & ~extension_pin;
		idle = (state_reg == cid_pkg::CID_ST_IDLE);
		xfer_done = cfg_reg.bus_width_bit | nib_phase_reg;
		cmd = cfg_reg.bus_width_bit ? host_data_in :
			{hi_nib_reg, host_data_in[7:4]};
		rbyte = 8'h00;
		unique case (state_reg)
			cid_pkg::CID_ST_INIT: begin
				// Defaults sit in cfg from reset; only the clear is issued
				if (cnt_reg == 20'(POWERON_CYCLES - 1))
					clr_stb_next = 1'b1;
				if (cnt_reg == 20'h00000)
					state_next = cid_pkg::CID_ST_IDLE;
				else
					cnt_next = cnt_reg - 20'h00001;
			end
			cid_pkg::CID_ST_BUSY: begin
				if (cnt_reg == 20'h00000)
					state_next = cid_pkg::CID_ST_IDLE;
				else
					cnt_next = cnt_reg - 20'h00001;
			end
			cid_pkg::CID_ST_IDLE: begin
				cnt_next = cnt_reg;
			end
		endcase
		// Writes only while idle; a busy write is dropped whole
		if (host_wr_stb && idle) begin
			if (!xfer_done) begin
				hi_nib_next = host_data_in[7:4];
				nib_phase_next = 1'b1;
			end else begin
				nib_phase_next = 1'b0;
				if (register_select_line) begin
					ram_wr_next.data = cmd;
					ram_wr_next.addr = ptr_reg;
					ram_wr_next.target = target_reg;
					wr_stb_next = 1'b1;
					ptr_next = cid_step(ptr_reg, cfg_reg.addr_increment,
						target_reg);
					if (cfg_reg.entry_shift)
						offset_next = cfg_reg.addr_increment ?
							7'(offset_reg + 7'h01) :
							7'(offset_reg - 7'h01);
					state_next = cid_pkg::CID_ST_BUSY;
					cnt_next = 20'(SHORT_CYCLES - 1);
				end else begin
					state_next = cid_pkg::CID_ST_BUSY;
					cnt_next = 20'(SHORT_CYCLES - 1);
					if (cmd[`CID_OP_ADDR_BIT]) begin
						if (cfg_reg.extension_enable) begin
							// Bit 3 is a don't-care
							cfg_next.dot_scroll_amount = cmd[6:4];
							ptr_next = {4'h0, cmd[2:0]};
						end else begin
							ptr_next = cmd[6:0];
							pat_sel_next = 1'b0;
						end
					end else if (cmd[`CID_OP_PATTERN_BIT]) begin
						if (!cfg_reg.extension_enable) begin
							ptr_next = {1'b0, cmd[5:0]};
							pat_sel_next = 1'b1;
						end else begin
							state_next = cid_pkg::CID_ST_IDLE;
							cnt_next = cnt_reg;
						end
					end else if (cmd[`CID_OP_FUNC_BIT]) begin
						cfg_next.bus_width_bit = cmd[4];
						cfg_next.two_line = cmd[3];
						cfg_next.extension_enable = cmd[2];
						if (cmd[2]) begin
							cfg_next.pattern_blink_enable = cmd[1];
							cfg_next.low_power_bit = cmd[0];
						end
					end else if (cmd[`CID_OP_SHIFT_BIT]) begin
						// Bits 1:0 are don't-cares
						if (cmd[3])
							offset_next = cmd[2] ? 7'(offset_reg + 7'h01) :
								7'(offset_reg - 7'h01);
						else
							ptr_next = cid_step(ptr_reg, cmd[2], target_reg);
					end else if (cmd[`CID_OP_DISPCTL_BIT]) begin
						if (cfg_reg.extension_enable) begin
							cfg_next.wide_font_bit = cmd[2];
							cfg_next.invert_cursor = cmd[1];
							cfg_next.four_line_bit = cmd[0];
						end else begin
							cfg_next.display_on = cmd[2];
							cfg_next.cursor_on = cmd[1];
							cfg_next.cursor_blink = cmd[0];
						end
					end else if (cmd[`CID_OP_ENTRY_BIT]) begin
						cfg_next.addr_increment = cmd[1];
						cfg_next.entry_shift = cmd[0];
					end else if (cmd[`CID_OP_HOME_BIT]) begin
						ptr_next = 7'h00;
						pat_sel_next = 1'b0;
						offset_next = 7'h00;
						cnt_next = 20'(LONG_CYCLES - 1);
					end else if (cmd[`CID_OP_CLEAR_BIT]) begin
						clr_stb_next = 1'b1;
						ptr_next = 7'h00;
						pat_sel_next = 1'b0;
						offset_next = 7'h00;
						cnt_next = 20'(LONG_CYCLES - 1);
					end else begin
						state_next = cid_pkg::CID_ST_IDLE;
						cnt_next = cnt_reg;
					end
				end
			end
		end else if (host_rd_stb) begin
			// Status answers at any time; data only while idle
			if (!register_select_line)
				rbyte = {!idle, ptr_reg};
			else if (idle)
				rbyte = ram_rd_data;
			dout_next = cfg_reg.bus_width_bit ? rbyte :
				(nib_phase_reg ? {rbyte[3:0], 4'h0} :
				{rbyte[7:4], 4'h0});
			nib_phase_next = !xfer_done;
			if (xfer_done && register_select_line && idle)
				ptr_next = cid_step(ptr_reg, cfg_reg.addr_increment,
					target_reg);
		end
		// Segment RAM while extended, else by the last address load
		target_next = cfg_next.extension_enable ?
			cid_pkg::CID_TGT_SEGMENT : (pat_sel_next ?
			cid_pkg::CID_TGT_PATTERN : cid_pkg::CID_TGT_DISPLAY);
	end

	// Registers; reset values are the power-on defaults
	always_ff @(posedge clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			state_reg <= cid_pkg::CID_ST_INIT;
			cfg_reg <= `CID_CFG_RESET;
			ram_wr_reg <= '0;
			target_reg <= cid_pkg::CID_TGT_DISPLAY;
			cnt_reg <= 20'(POWERON_CYCLES - 1);
			ptr_reg <= 7'h00;
			offset_reg <= 7'h00;
			dout_reg <= 8'h00;
			hi_nib_reg <= 4'h0;
			nib_phase_reg <= 1'b0;
			pat_sel_reg <= 1'b0;
			wr_stb_reg <= 1'b0;
			clr_stb_reg <= 1'b0;
			lowpwr_act_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cfg_reg <= cfg_next;
			ram_wr_reg <= ram_wr_next;
			target_reg <= target_next;
			cnt_reg <= cnt_next;
			ptr_reg <= ptr_next;
			offset_reg <= offset_next;
			dout_reg <= dout_next;
			hi_nib_reg <= hi_nib_next;
			nib_phase_reg <= nib_phase_next;
			pat_sel_reg <= pat_sel_next;
			wr_stb_reg <= wr_stb_next;
			clr_stb_reg <= clr_stb_next;
			lowpwr_act_reg <= lowpwr_act_next;
		end
	end

	// Outputs straight from flops
	assign host_data_out = dout_reg;
	assign ram_wr_stb = wr_stb_reg;
	assign ram_wr = ram_wr_reg;
	assign ram_target = target_reg;
	assign ram_pointer = ptr_reg;
	assign display_clear_stb = clr_stb_reg;
	assign cfg = cfg_reg;
	assign display_offset = offset_reg;
	assign low_power_active = lowpwr_act_reg;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n_sync);

	logic cmd8_ok;
	assign cmd8_ok = host_wr_stb && idle && !register_select_line &&
		cfg_reg.bus_width_bit;

	init_defaults_a: assert property (
		state_reg == cid_pkg::CID_ST_INIT |-> cfg_reg == `CID_CFG_RESET)
		else $error("defaults lost during init");
	busy_status_a: assert property (
		host_rd_stb && !register_select_line && cfg_reg.bus_width_bit
		&& !host_wr_stb |=> dout_reg == {$past(!idle), $past(ptr_reg)})
		else $error("status byte wrong");
	busy_reject_a: assert property (
		host_wr_stb && !idle |=> $stable(cfg_reg) && !wr_stb_reg
		&& $stable(ptr_reg)) else $error("write taken while busy");
	entry_mode_a: assert property (
		cmd8_ok && host_data_in[7:2] == 6'h01 |=> cfg_reg.addr_increment
		== $past(host_data_in[1]) && cnt_reg == 20'(SHORT_CYCLES - 1)
		&& state_reg == cid_pkg::CID_ST_BUSY)
		else $error("entry mode not applied");
	home_long_a: assert property (
		cmd8_ok && host_data_in[7:1] == 7'h01 |=> ptr_reg == 7'h00 &&
		offset_reg == 7'h00 && cnt_reg == 20'(LONG_CYCLES - 1))
		else $error("home wrong");
	data_step_a: assert property (
		host_wr_stb && idle && register_select_line &&
		cfg_reg.bus_width_bit && target_reg == cid_pkg::CID_TGT_DISPLAY
		&& cfg_reg.addr_increment |=> wr_stb_reg &&
		ram_wr_reg.data == $past(host_data_in) &&
		ptr_reg == 7'($past(ptr_reg) + 7'h01))
		else $error("data write or step wrong");
	func_plain_a: assert property (
		cmd8_ok && host_data_in[7:5] == 3'h1 && !host_data_in[2] |=>
		$stable(cfg_reg.pattern_blink_enable) &&
		$stable(cfg_reg.low_power_bit)) else $error("low bits not ignored");
	nibble_first_a: assert property (
		host_wr_stb && idle && !cfg_reg.bus_width_bit && !nib_phase_reg
		|=> nib_phase_reg && !wr_stb_reg && $stable(cfg_reg))
		else $error("first nibble acted");
	low_power_a: assert property (
		extension_pin |=> !lowpwr_act_reg)
		else $error("low power with pin high");
	no_op_a: assert property (
		cmd8_ok && host_data_in == 8'h00 |=> idle && $stable(cfg_reg))
		else $error("null code acted");
	busy_end_a: assert property (
		state_reg == cid_pkg::CID_ST_BUSY && cnt_reg == 20'h00000 |=> idle)
		else $error("busy did not end");

	clear_cov: cover property (cmd8_ok && host_data_in == 8'h01);
	nibble_cov: cover property (host_wr_stb && idle && nib_phase_reg);
	seg_cov: cover property (wr_stb_reg &&
		ram_wr_reg.target == cid_pkg::CID_TGT_SEGMENT);
	busy_rd_cov: cover property (host_rd_stb && !idle);
endmodule

// file: tb/cid_host_model.sv
`timescale 1ns/100ps
module cid_host_model (
	// Clock
	input wire logic clk,
	// Host side of the bus
	output logic host_wr_stb,
	output logic host_rd_stb,
	output logic register_select_line,
	output logic [7:0] host_data_in,
	input wire logic [7:0] host_data_out
);
	// ****************************************************************
	// Bus state
	// ****************************************************************
	logic nib_mode = 1'b0;
	int timeouts = 0;

	// Quiet bus at time zero
	initial begin
		host_wr_stb = 1'b0;
		host_rd_stb = 1'b0;
		register_select_line = 1'b0;
		host_data_in = 8'h00;
	end

	// One strobe; released data lines show the inverse, never a stale value
	task automatic strobe(input logic sel, input logic wr,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge clk);
		register_select_line <= sel;
		host_wr_stb <= wr;
		host_rd_stb <= !wr;
		host_data_in <= d;
		@(posedge clk);
		host_wr_stb <= 1'b0;
		host_rd_stb <= 1'b0;
		host_data_in <= ~d;
		@(posedge clk);
		#1 q = host_data_out;
	endtask

	// A byte moves whole; narrow mode sends high nibble first
	task automatic xfer(input logic sel, input logic wr,
		input logic [7:0] d, output logic [7:0] q);
		logic [7:0] hi;
		logic [7:0] lo;
		if (nib_mode) begin
			strobe(sel, wr, d, hi);
			strobe(sel, wr, {d[3:0], 4'h0}, lo);
			q = {hi[7:4], lo[7:4]};
		end else begin
			strobe(sel, wr, d, q);
		end
	endtask

	task automatic status(output logic [7:0] s);
		xfer(1'b0, 1'b0, 8'h00, s);
	endtask

	// Bounded poll: a stuck pending flag counts as a timeout
	task automatic wait_idle();
		logic [7:0] s;
		int n;
		s = 8'hFF;
		n = 0;
		while (s[7] !== 1'b0 && n < 4000) begin
			status(s);
			n++;
		end
		if (n >= 4000)
			timeouts++;
	endtask

	task automatic send(input logic sel, input logic [7:0] d);
		logic [7:0] q;
		wait_idle();
		xfer(sel, 1'b1, d, q);
	endtask
endmodule

// file: tb/tb.sv
`timescale 1ns/100ps
module tb;
	// ****************************************************************
	// Signals and bench state
	// ****************************************************************
	typedef struct {
		logic [7:0] code;
		logic [15:0] cfg;
		logic [6:0] ptr;
		logic [1:0] tgt;
	} cid_row_t;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic extension_pin = 1'b0;
	logic [7:0] ram_rd_data = 8'hA5;
	logic host_wr_stb, host_rd_stb, register_select_line;
	logic [7:0] host_data_in, host_data_out, s;
	logic ram_wr_stb, display_clear_stb, low_power_active;
	cid_pkg::cid_ram_wr_t ram_wr, last_wr;
	cid_pkg::cid_target_t ram_target;
	cid_pkg::cid_cfg_t cfg;
	logic [6:0] ram_pointer, display_offset, off0;
	int errors = 0;
	int cmp_count = 0;
	int cycles = 0;
	int clears = 0;
	int t0;
	// Code sent, then settings, pointer and RAM target expected
	cid_row_t rows [13] = '{
		'{8'h0F, 16'hE210, 7'h00, 2'h0},
		'{8'h05, 16'hE208, 7'h00, 2'h0},
		'{8'h06, 16'hE210, 7'h00, 2'h0},
		'{8'h3B, 16'hE310, 7'h00, 2'h0},
		'{8'h3F, 16'hE3F0, 7'h00, 2'h2},
		'{8'h0D, 16'hF7F0, 7'h00, 2'h2},
		'{8'hDD, 16'hF7F5, 7'h05, 2'h2},
		'{8'h4A, 16'hF7F5, 7'h05, 2'h2},
		'{8'h30, 16'hF675, 7'h05, 2'h0},
		'{8'h4A, 16'hF675, 7'h0A, 2'h1},
		'{8'h85, 16'hF675, 7'h05, 2'h0},
		'{8'h00, 16'hF675, 7'h05, 2'h0},
		'{8'h10, 16'hF675, 7'h04, 2'h0}
	};

	// ****************************************************************
	// Design and host
	// ****************************************************************
	cid_top #(.POWERON_CYCLES(20), .LONG_CYCLES(10)) i_dut (
		.clk(clk), .reset_n(reset_n), .host_wr_stb(host_wr_stb),
		.host_rd_stb(host_rd_stb),
		.register_select_line(register_select_line),
		.host_data_in(host_data_in), .host_data_out(host_data_out),
		.extension_pin(extension_pin), .ram_rd_data(ram_rd_data),
		.ram_wr_stb(ram_wr_stb), .ram_wr(ram_wr), .ram_target(ram_target),
		.ram_pointer(ram_pointer), .display_clear_stb(display_clear_stb),
		.cfg(cfg), .display_offset(display_offset),
		.low_power_active(low_power_active));
	cid_host_model i_host (
		.clk(clk), .host_wr_stb(host_wr_stb), .host_rd_stb(host_rd_stb),
		.register_select_line(register_select_line),
		.host_data_in(host_data_in), .host_data_out(host_data_out));

	// 40 MHz clock
	always #12.5 clk = ~clk;

	task automatic check(input string what, input logic [23:0] exp,
		input logic [23:0] got);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic results();
		errors += i_host.timeouts;
		if (errors == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Pulses sampled mid-cycle, clear of the launching edge; hang guard
	always @(negedge clk) begin
		cycles++;
		if (display_clear_stb === 1'b1)
			clears++;
		if (ram_wr_stb === 1'b1)
			last_wr = ram_wr;
		if (cycles == 90000) begin
			errors++;
			results();
		end
	end

	// ****************************************************************
	// Sequence
	// ****************************************************************
	initial begin
		repeat (16) @(posedge clk);
		check("cfg", 16'h0210, cfg);
		reset_n <= 1'b1;
		t0 = cycles;
		// Logic leaves reset two edges after release
		repeat (2) @(posedge clk);
		i_host.status(s);
		check("busy", 1'b1, s[7]);
		i_host.wait_idle();
		check("init time", 1'b1, cycles - t0 >= 20);
		check("cfg", 16'h0210, cfg);
		check("clears", 1'b1, clears == 1);
		check("ptr", 7'h00, ram_pointer);
		foreach (rows[i]) begin
			i_host.send(1'b0, rows[i].code);
			i_host.wait_idle();
			check("cfg", rows[i].cfg, cfg);
			check("ptr", rows[i].ptr, ram_pointer);
			check("target", rows[i].tgt, ram_target);
		end
		check("low power", 1'b1, low_power_active);
		@(posedge clk) extension_pin <= 1'b1;
		repeat (3) @(posedge clk);
		check("low power", 1'b0, low_power_active);
		extension_pin <= 1'b0;
		i_host.send(1'b1, 8'h41);
		check("ram write", {cid_pkg::CID_TGT_DISPLAY, 7'h04, 8'h41},
			last_wr);
		check("ptr", 7'h05, ram_pointer);
		i_host.send(1'b0, 8'h04);
		i_host.send(1'b1, 8'h42);
		check("ptr", 7'h04, ram_pointer);
		off0 = display_offset;
		i_host.send(1'b0, 8'h07);
		i_host.send(1'b1, 8'h43);
		check("offset", 7'(off0 + 7'h01), display_offset);
		i_host.wait_idle();
		i_host.xfer(1'b1, 1'b0, 8'h00, s);
		check("read", 8'hA5, s);
		check("ptr", 7'h06, ram_pointer);
		i_host.send(1'b0, 8'h02);
		i_host.wait_idle();
		check("ptr", 7'h00, ram_pointer);
		check("offset", 7'h00, display_offset);
		// Display shift left leaves the pointer alone
		i_host.send(1'b0, 8'h18);
		check("offset", 7'h7F, display_offset);
		check("ptr", 7'h00, ram_pointer);
		// Write while busy must be dropped
		i_host.send(1'b0, 8'h08);
		i_host.xfer(1'b0, 1'b1, 8'h0F, s);
		i_host.status(s);
		check("status", 8'h80, s);
		i_host.wait_idle();
		check("display on", 1'b0, cfg.display_on);
		i_host.send(1'b0, 8'h93);
		t0 = clears;
		i_host.send(1'b0, 8'h01);
		i_host.wait_idle();
		check("clears", 1'b1, clears == t0 + 1);
		check("ptr", 7'h00, ram_pointer);
		// Extended mode sends data to segment RAM
		i_host.send(1'b0, 8'h34);
		i_host.send(1'b0, 8'h83);
		i_host.send(1'b1, 8'h1F);
		check("seg write", {cid_pkg::CID_TGT_SEGMENT, 7'h03, 8'h1F},
			last_wr);
		check("ptr", 7'h04, ram_pointer);
		i_host.send(1'b0, 8'h30);
		// Narrow mode from the very next transfer
		i_host.send(1'b0, 8'h20);
		i_host.nib_mode = 1'b1;
		i_host.wait_idle();
		check("width", 1'b0, cfg.bus_width_bit);
		i_host.send(1'b0, 8'h8C);
		i_host.wait_idle();
		i_host.status(s);
		check("status", 8'h0C, s);
		// Mid-run reset brings back the power-on state
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		check("cfg", 16'h0210, cfg);
		check("ptr", 7'h00, ram_pointer);
		reset_n <= 1'b1;
		i_host.nib_mode = 1'b0;
		repeat (2) @(posedge clk);
		i_host.status(s);
		check("busy", 1'b1, s[7]);
		i_host.wait_idle();
		check("clears", 1'b1, clears == t0 + 2);
		check("width", 1'b1, cfg.bus_width_bit);
		results();
	end
endmodule
